//--- sccr_edge_detector.sv
// sccr_edge_detector: alignment-edge history, position capture, delay tap
// assumes: i_align is already synchronised and polarity corrected
`timescale 1ns/10ps
module sccr_edge_detector
    import sccr_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic                      i_align,
    input  wire logic                      i_receiver_enable,
    input  wire logic                      i_zoom,
    input  wire logic [sccr_pkg::SEL_W-1:0] i_delay_select,
    output logic      [sccr_pkg::POS_W-1:0] o_position,
    output logic                           o_align_delayed
);
    logic [HIST_W-1:0] history;
    logic [HIST_W-1:0] next_history;
    logic              phase;
    logic              next_phase;
    logic              align_q;
    logic [POS_W-1:0]  next_position;
    logic              next_align_delayed;

    always_comb begin
        next_phase         = ~phase;
        next_history       = history;
        next_position      = o_position;
        // zoom: one tap per clock, otherwise one tap per two clocks
        if (i_zoom || phase) begin
            next_history = {history[HIST_W-2:0], i_align};
        end
        // capture where the edge sits in the tap history
        if (i_receiver_enable && i_align && !align_q) begin
            next_position = history;
        end
        next_align_delayed = history[i_delay_select];
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            history         <= '0;
            phase           <= 1'b0;
            align_q         <= 1'b0;
            o_position      <= RST_ALIGN_EDGE_POSITION;
            o_align_delayed <= 1'b0;
        end else begin
            history         <= next_history;
            phase           <= next_phase;
            align_q         <= i_align;
            o_position      <= next_position;
            o_align_delayed <= next_align_delayed;
        end
    end
endmodule

//--- sccr_host.sv
// sccr_host: serial register-port master in place of the host controller
// assumes: six clocks per sclk half period, over three device clocks
`timescale 1ns/10ps
module sccr_host (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output logic      o_cs_b,
    output logic      o_sclk,
    output logic      o_sdi
);
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    // read flag, address, then n bytes from the top of wd
    task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                        input logic [23:0] wd, output logic [23:0] rv);
        logic [39:0] sh;
        sh = {rd, a, wd};
        rv = '0;
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++) begin
            repeat (6) @(posedge i_clk);
            o_sclk <= 1'b0;
            o_sdi  <= sh[39];
            sh = sh << 1;
            repeat (6) @(posedge i_clk);
            if (rd && i >= 16) begin
                rv = {rv[22:0], i_sdo_oe ? i_sdo : 1'bx};
            end
            o_sclk <= 1'b1;
        end
        repeat (6) @(posedge i_clk);
        o_cs_b <= 1'b1;
        // released line flips so no stale level passes for data
        o_sdi  <= ~o_sdi;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

//--- sccr_pkg.sv
// sccr_pkg: register map, field layouts and serial-frame constants
// assumes: byte-wide registers behind a 16-bit-header serial port
package sccr_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int POS_W  = 24;
    localparam int SAMP_W = 12;
    localparam int SEL_W  = 4;
    localparam int HIST_W = 24;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_ALIGN_REF_CONTROL   = 15'h0029;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_INPUT_OPTIONS = 15'h002A;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLE_CLOCK_TUNING = 15'h002B;
    localparam logic [ADDR_W-1:0] ADDR_ALIGN_POS_BYTE0     = 15'h002C;
    localparam logic [ADDR_W-1:0] ADDR_ALIGN_POS_BYTE1     = 15'h002D;
    localparam logic [ADDR_W-1:0] ADDR_ALIGN_POS_BYTE2     = 15'h002E;

    // reset values and the value read from unmapped addresses
    localparam logic [DATA_W-1:0] RST_ALIGN_REF_CONTROL   = 8'h00;
    localparam logic [DATA_W-1:0] RST_CLOCK_INPUT_OPTIONS = 8'h00;
    localparam logic [DATA_W-1:0] RST_SAMPLE_CLOCK_TUNING = 8'h11;
    localparam logic [POS_W-1:0]  RST_ALIGN_EDGE_POSITION = 24'h00_0000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED           = 8'h00;

    // serial frame: 1 read flag, 15 address bits, then data bytes
    localparam logic [4:0] HDR_BITS  = 5'd16;
    localparam logic [3:0] BYTE_BITS = 4'd8;
    localparam logic [3:0] BYTE_ZERO = 4'd0;
    localparam logic [4:0] HDR_ZERO  = 5'd0;
    localparam int         RD_FLAG   = 15;

    // pin synchroniser bit order {sysref, sdi, sclk, cs_b}
    localparam int         PIN_W     = 4;
    localparam int         PIN_CS_B  = 0;
    localparam int         PIN_SCLK  = 1;
    localparam int         PIN_SDI   = 2;
    localparam int         PIN_ALIGN = 3;
    localparam logic [3:0] PIN_RST   = 4'h1;

    typedef struct packed {
        logic             reserved7;
        logic             align_processor_enable;
        logic             align_receiver_enable;
        logic             window_zoom;
        logic [SEL_W-1:0] align_delay_select;
    } sccr_align_ref_control_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic       align_as_timestamp_enable;
        logic       devclock_dc_input_mode;
        logic       align_dc_input_mode;
        logic       align_polarity_invert;
    } sccr_clock_input_options_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic       feedback_gain_high;
        logic       reserved3;
        logic       supply_noise_suppress;
        logic [1:0] sample_clock_delay;
    } sccr_sample_clock_tuning_t;

    typedef struct packed {
        logic                    devclock_dc_input_mode;
        logic                    align_dc_input_mode;
        logic                    align_receiver_enable;
        logic                    supply_noise_suppress;
        logic                    feedback_gain_high;
        logic [1:0]              sample_clock_delay;
    } sccr_analog_ctrl_t;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_HDR  = 3'b010,
        SER_DATA = 3'b100
    } sccr_ser_state_t;

endpackage

//--- sccr_regs.sv
// sccr_regs: alignment-reference clock-control register bank
// serial register port, control outputs, edge position status,
// alignment event output and timestamp insertion on sample LSB.
// assumes: serial clock well below i_clk/4; pins are asynchronous.
`timescale 1ns/10ps
module sccr_regs
    import sccr_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_soft_reset,
    input  wire logic                        i_cs_b,
    input  wire logic                        i_sclk,
    input  wire logic                        i_sdi,
    output logic                             o_sdo,
    output logic                             o_sdo_oe,
    input  wire logic                        i_sysref,
    input  wire logic                        i_global_timestamp_enable,
    input  wire logic                        i_decimation_is_one,
    input  wire logic [sccr_pkg::SAMP_W-1:0] i_sample,
    output logic      [sccr_pkg::SAMP_W-1:0] o_sample,
    output sccr_pkg::sccr_analog_ctrl_t      o_analog_ctrl,
    output logic                             o_window_zoom,
    output logic      [sccr_pkg::SEL_W-1:0]  o_align_delay_select,
    output logic                             o_align_event
);
    import sccr_pkg::*;

    // pin synchronisers
    logic [PIN_W-1:0] pins_s;
    logic             sclk_q;

    sccr_sync #(
        .WIDTH     (PIN_W),
        .RESET_VAL (PIN_RST)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_sysref, i_sdi, i_sclk, i_cs_b}),
        .o_sync  (pins_s)
    );

    logic cs_b_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sdi_s;
    logic sysref_s;

    assign cs_b_s    = pins_s[PIN_CS_B];
    assign sdi_s     = pins_s[PIN_SDI];
    assign sysref_s  = pins_s[PIN_ALIGN];
    assign sclk_rise = pins_s[PIN_SCLK] & ~sclk_q;
    assign sclk_fall = ~pins_s[PIN_SCLK] & sclk_q;

    // register state
    sccr_align_ref_control_t   ctrl0;
    sccr_clock_input_options_t ctrl1;
    sccr_sample_clock_tuning_t ctrl2;
    sccr_align_ref_control_t   next_ctrl0;
    sccr_clock_input_options_t next_ctrl1;
    sccr_sample_clock_tuning_t next_ctrl2;
    logic [POS_W-1:0]          position;

    // serial engine state
    sccr_ser_state_t   state;
    sccr_ser_state_t   next_state;
    logic [4:0]        hdr_cnt;
    logic [4:0]        next_hdr_cnt;
    logic [3:0]        bit_cnt;
    logic [3:0]        next_bit_cnt;
    logic [ADDR_W:0]   hdr;
    logic [ADDR_W:0]   next_hdr;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic              rd;
    logic              next_rd;
    logic [DATA_W-1:0] rx;
    logic [DATA_W-1:0] next_rx;
    logic [DATA_W-1:0] tx;
    logic [DATA_W-1:0] next_tx;
    logic [DATA_W-1:0] wr_byte;
    logic              wr_en;

    // read mux
    function automatic logic [DATA_W-1:0] read_byte(
        input logic [ADDR_W-1:0] a
    );
        logic [DATA_W-1:0] v;
        v = READ_UNMAPPED;
        case (a)
            ADDR_ALIGN_REF_CONTROL:   v = ctrl0;
            ADDR_CLOCK_INPUT_OPTIONS: v = ctrl1;
            ADDR_SAMPLE_CLOCK_TUNING: v = ctrl2;
            ADDR_ALIGN_POS_BYTE0:     v = position[7:0];
            ADDR_ALIGN_POS_BYTE1:     v = position[15:8];
            ADDR_ALIGN_POS_BYTE2:     v = position[23:16];
            default:                  v = READ_UNMAPPED;
        endcase
        return v;
    endfunction

    always_comb begin
        next_state   = state;
        next_hdr_cnt = hdr_cnt;
        next_bit_cnt = bit_cnt;
        next_hdr     = hdr;
        next_addr    = addr;
        next_rd      = rd;
        next_rx      = rx;
        next_tx      = tx;
        wr_en        = 1'b0;
        wr_byte      = {rx[DATA_W-2:0], sdi_s};
        if (cs_b_s) begin
            next_state   = SER_IDLE;
            next_hdr_cnt = HDR_ZERO;
            next_bit_cnt = BYTE_ZERO;
        end else begin
            case (state)
                SER_IDLE: begin
                    next_state   = SER_HDR;
                    next_hdr_cnt = HDR_ZERO;
                end
                SER_HDR: begin
                    if (sclk_rise) begin
                        next_hdr     = {hdr[ADDR_W-1:0], sdi_s};
                        next_hdr_cnt = hdr_cnt + 5'd1;
                        if (next_hdr_cnt == HDR_BITS) begin
                            next_state   = SER_DATA;
                            next_rd      = next_hdr[RD_FLAG];
                            next_addr    = next_hdr[ADDR_W-1:0];
                            next_tx      = read_byte(next_hdr[ADDR_W-1:0]);
                            next_bit_cnt = BYTE_ZERO;
                        end
                    end
                end
                SER_DATA: begin
                    if (sclk_rise) begin
                        next_rx      = wr_byte;
                        next_bit_cnt = bit_cnt + 4'd1;
                        if (next_bit_cnt == BYTE_BITS) begin
                            wr_en        = ~rd;
                            next_addr    = addr + 15'h0001;
                            next_bit_cnt = BYTE_ZERO;
                        end
                    end else if (sclk_fall) begin
                        // last bit of a byte stands until the fall,
                        // then the next streamed byte is loaded
                        if (bit_cnt == BYTE_ZERO) begin
                            next_tx = read_byte(addr);
                        end else begin
                            next_tx = {tx[DATA_W-2:0], 1'b0};
                        end
                    end
                end
                default: next_state = SER_IDLE;
            endcase
        end
    end

    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        if (i_soft_reset) begin
            // reset values for all three registers
            next_ctrl0 = RST_ALIGN_REF_CONTROL;
            next_ctrl2 = RST_SAMPLE_CLOCK_TUNING;
            next_ctrl1 = RST_CLOCK_INPUT_OPTIONS;
        end else if (wr_en) begin
            case (addr)
                ADDR_ALIGN_REF_CONTROL:   next_ctrl0 = wr_byte;
                ADDR_CLOCK_INPUT_OPTIONS: next_ctrl1 = wr_byte;
                ADDR_SAMPLE_CLOCK_TUNING: next_ctrl2 = wr_byte;
                default:                  next_ctrl0 = ctrl0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q  <= 1'b0;
            state   <= SER_IDLE;
            hdr_cnt <= HDR_ZERO;
            bit_cnt <= BYTE_ZERO;
            hdr     <= '0;
            addr    <= '0;
            rd      <= 1'b0;
            rx      <= '0;
            tx      <= '0;
            ctrl0   <= RST_ALIGN_REF_CONTROL;
            ctrl1   <= RST_CLOCK_INPUT_OPTIONS;
            ctrl2   <= RST_SAMPLE_CLOCK_TUNING;
        end else begin
            sclk_q  <= pins_s[PIN_SCLK];
            state   <= next_state;
            hdr_cnt <= next_hdr_cnt;
            bit_cnt <= next_bit_cnt;
            hdr     <= next_hdr;
            addr    <= next_addr;
            rd      <= next_rd;
            rx      <= next_rx;
            tx      <= next_tx;
            ctrl0   <= next_ctrl0;
            ctrl1   <= next_ctrl1;
            ctrl2   <= next_ctrl2;
        end
    end

    // serial read data, driven only during read data phase
    assign o_sdo    = tx[DATA_W-1];
    assign o_sdo_oe = ~cs_b_s & rd & (state == SER_DATA);

    // alignment input path
    logic align_in;
    logic align_delayed;
    logic align_delayed_q;
    logic next_align_event;
    logic ts_active;
    logic [SAMP_W-1:0] next_sample;

    assign align_in = (sysref_s & ctrl0.align_receiver_enable) ^ ctrl1.align_polarity_invert;

    sccr_edge_detector u_edge_detector (
        .i_clk             (i_clk),
        .i_rst_b           (i_rst_b),
        .i_align           (align_in),
        .i_receiver_enable (ctrl0.align_receiver_enable),
        .i_zoom            (ctrl0.window_zoom),
        .i_delay_select    (ctrl0.align_delay_select),
        .o_position        (position),
        .o_align_delayed   (align_delayed)
    );

    always_comb begin
        next_align_event = ctrl0.align_processor_enable & align_delayed & ~align_delayed_q;
        ts_active   = ctrl1.align_as_timestamp_enable & i_global_timestamp_enable
                    & i_decimation_is_one;
        next_sample = ts_active ? {i_sample[SAMP_W-1:1], align_in} : i_sample;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            align_delayed_q <= 1'b0;
            o_align_event   <= 1'b0;
            o_sample        <= '0;
        end else begin
            align_delayed_q <= align_delayed;
            o_align_event   <= next_align_event;
            o_sample        <= next_sample;
        end
    end

    always_comb begin
        o_analog_ctrl.devclock_dc_input_mode = ctrl1.devclock_dc_input_mode;
        o_analog_ctrl.align_dc_input_mode    = ctrl1.align_dc_input_mode;
        o_analog_ctrl.align_receiver_enable  = ctrl0.align_receiver_enable;
        o_analog_ctrl.supply_noise_suppress  = ctrl2.supply_noise_suppress;
        o_analog_ctrl.feedback_gain_high     = ctrl2.feedback_gain_high;
        o_analog_ctrl.sample_clock_delay     = ctrl2.sample_clock_delay;
        o_window_zoom                        = ctrl0.window_zoom;
        o_align_delay_select                 = ctrl0.align_delay_select;
    end
endmodule

//--- sccr_regs_asserts.sv
// sccr_regs_asserts: port-level checks of the clock-control register bank
// assumes: bound to sccr_regs, one i_clk domain
`timescale 1ns/10ps
module sccr_regs_asserts
    import sccr_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_soft_reset,
    input  wire logic                        i_cs_b,
    input  wire logic                        i_sclk,
    input  wire logic                        i_global_timestamp_enable,
    input  wire logic                        i_decimation_is_one,
    input  wire logic [sccr_pkg::SAMP_W-1:0] i_sample,
    input  wire logic [sccr_pkg::SAMP_W-1:0] o_sample,
    input  wire logic                        o_sdo,
    input  wire logic                        o_sdo_oe,
    input  wire sccr_pkg::sccr_analog_ctrl_t o_analog_ctrl,
    input  wire logic                        o_window_zoom,
    input  wire logic [sccr_pkg::SEL_W-1:0]  o_align_delay_select,
    input  wire logic                        o_align_event
);
    localparam sccr_analog_ctrl_t ANALOG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'b01};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    event_pulse_a:
        assert property (o_align_event |=> !o_align_event)
        else $error("alignment event wider than one cycle");
    sample_pass_a:
        assert property ($past(i_rst_b) && !($past(i_global_timestamp_enable)
            && $past(i_decimation_is_one)) |-> o_sample == $past(i_sample))
        else $error("sample altered without timestamp conditions");
    sample_upper_a:
        assert property ($past(i_rst_b) |-> o_sample[SAMP_W-1:1] == $past(i_sample[SAMP_W-1:1]))
        else $error("upper sample bits not passed through");
    idle_no_drive_a:
        assert property (i_cs_b [*5] |-> !o_sdo_oe)
        else $error("serial output driven while deselected");
    sdo_hold_a:
        assert property (o_sdo_oe && $rose(i_sclk) |-> $stable(o_sdo) [*5])
        else $error("serial output changed around sampling edge");
    regs_hold_a:
        assert property (i_cs_b [*6] ##0 !$past(i_soft_reset) |-> $stable(o_analog_ctrl)
            && $stable(o_window_zoom) && $stable(o_align_delay_select))
        else $error("control outputs changed without access");
    soft_defaults_a:
        assert property (i_soft_reset |=> o_analog_ctrl == ANALOG_RST && !o_window_zoom
            && o_align_delay_select == '0)
        else $error("soft reset did not restore controls");
    release_defaults_a:
        assert property ($rose(i_rst_b) |-> o_analog_ctrl == ANALOG_RST && !o_window_zoom)
        else $error("controls not at reset values after reset");

    cover property (o_align_event);
    cover property (o_sdo_oe && $rose(i_sclk));
    cover property (o_sample[0] && !i_sample[0]);
endmodule

bind sccr_regs sccr_regs_asserts u_asserts (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_soft_reset(i_soft_reset),
    .i_cs_b(i_cs_b), .i_sclk(i_sclk), .i_sample(i_sample), .o_sample(o_sample),
    .i_global_timestamp_enable(i_global_timestamp_enable),
    .i_decimation_is_one(i_decimation_is_one), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_analog_ctrl(o_analog_ctrl), .o_window_zoom(o_window_zoom),
    .o_align_delay_select(o_align_delay_select), .o_align_event(o_align_event)
);

//--- sccr_sync.sv
// sccr_sync: two-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to i_clk
`timescale 1ns/10ps
module sccr_sync #(
    parameter int                WIDTH     = 4,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta   <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

//--- test_sysref_clock_control_regs.sv
// test_sysref_clock_control_regs: directed tests of the clock-control bank
// assumes: sccr_host drives the serial port, 25 MHz clock
`timescale 1ns/10ps
module test_sysref_clock_control_regs;
    import sccr_pkg::*;

    logic                    clk;
    logic                    rst_b;
    logic                    soft_reset;
    logic                    sysref;
    logic                    gts_en;
    logic                    dec_one;
    logic [SAMP_W-1:0]       sample;
    logic [SAMP_W-1:0]       sample_out;
    logic                    cs_b;
    logic                    sclk;
    logic                    sdi;
    logic                    sdo;
    logic                    sdo_oe;
    sccr_analog_ctrl_t       analog;
    logic                    zoom;
    logic [SEL_W-1:0]        sel;
    logic                    evt;
    logic [23:0]             r;
    logic [3:0]              k;
    int                      fail_count = 0;
    int                      compares = 0;
    int                      lat_slow;
    int                      lat_fast;

    sccr_host host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
                    .o_cs_b(cs_b), .o_sclk(sclk), .o_sdi(sdi));

    sccr_regs dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_soft_reset(soft_reset), .i_cs_b(cs_b),
        .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sysref(sysref),
        .i_global_timestamp_enable(gts_en), .i_decimation_is_one(dec_one),
        .i_sample(sample), .o_sample(sample_out), .o_analog_ctrl(analog),
        .o_window_zoom(zoom), .o_align_delay_select(sel), .o_align_event(evt)
    );

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [23:0] v;
        host.xfer(1'b0, a, 1, {d, 16'h0000}, v);
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        logic [23:0] v;
        host.xfer(1'b1, a, 1, 24'h00_0000, v);
        check(v, {16'h0000, exp});
    endtask

    task automatic check_defaults();
        rd(ADDR_ALIGN_REF_CONTROL, 8'h00);
        rd(ADDR_CLOCK_INPUT_OPTIONS, 8'h00);
        rd(ADDR_SAMPLE_CLOCK_TUNING, 8'h11);
        check(24'(analog), 24'h00_0005);
        check({19'h0, zoom, sel}, 24'h00_0000);
    endtask

    // drive the alignment pin, count event pulses for 40 cycles
    task automatic drive(input logic v, input int exp);
        int c;
        c = 0;
        @(posedge clk);
        sysref <= v;
        repeat (40) begin
            @(posedge clk);
            if (evt === 1'b1) begin
                c++;
            end
        end
        check(24'(c), 24'(exp));
    endtask

    // cycles from an alignment rise to its event, 60 at most
    task automatic latency(output int c);
        c = 0;
        @(posedge clk);
        sysref <= 1'b1;
        while (evt !== 1'b1 && c < 60) begin
            @(posedge clk);
            c++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        soft_reset = 1'b0;
        sysref = 1'b0;
        gts_en = 1'b0;
        dec_one = 1'b0;
        sample = 12'hABC;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check_defaults();
        host.xfer(1'b1, ADDR_ALIGN_POS_BYTE0, 3, 24'h00_0000, r);
        check({r[7:0], r[15:8], r[23:16]}, 24'h00_0000);
        rd(15'h0030, 8'h00);
        $display("test reset_values done");

        wr(ADDR_SAMPLE_CLOCK_TUNING, 8'hEE);
        wr(ADDR_CLOCK_INPUT_OPTIONS, 8'hF6);
        wr(ADDR_ALIGN_REF_CONTROL, 8'hBA);
        rd(ADDR_SAMPLE_CLOCK_TUNING, 8'hEE);
        rd(ADDR_CLOCK_INPUT_OPTIONS, 8'hF6);
        rd(ADDR_ALIGN_REF_CONTROL, 8'hBA);
        check(24'(analog), 24'h00_007A);
        check({19'h0, zoom, sel}, 24'h00_001A);
        wr(ADDR_ALIGN_POS_BYTE1, 8'h5A);
        rd(ADDR_ALIGN_POS_BYTE1, 8'h00);
        wr(15'h0030, 8'hFF);
        rd(15'h0030, 8'h00);
        $display("test field_map done");

        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        check_defaults();
        $display("test soft_reset done");

        wr(ADDR_ALIGN_REF_CONTROL, 8'h20);
        drive(1'b1, 0);
        wr(ADDR_ALIGN_REF_CONTROL, 8'h60);
        drive(1'b0, 0);
        drive(1'b1, 1);
        wr(ADDR_CLOCK_INPUT_OPTIONS, 8'h01);
        drive(1'b1, 0);
        drive(1'b0, 1);
        $display("test align_events done");

        wr(ADDR_CLOCK_INPUT_OPTIONS, 8'h00);
        drive(1'b1, 1);
        for (k = 4'd0; k < 4'd8; k++) begin
            wr(ADDR_CLOCK_INPUT_OPTIONS, {4'h0, k[2], 3'b000});
            @(posedge clk);
            gts_en <= k[1];
            dec_one <= k[0];
            repeat (3) @(posedge clk);
            check(24'(sample_out), 24'(12'hABC | 12'(k == 4'd7)));
        end
        $display("test timestamp done");

        wr(ADDR_ALIGN_REF_CONTROL, 8'h6F);
        drive(1'b0, 0);
        latency(lat_slow);
        wr(ADDR_ALIGN_REF_CONTROL, 8'h7F);
        drive(1'b0, 0);
        latency(lat_fast);
        check(24'(lat_fast < lat_slow && lat_slow < 60), 24'h00_0001);
        $display("test delay_select done");
        conclude();
    end
endmodule
